// ---- rtl/sdac_consts.vh ----
// Constants for the synthesizer divider and access configuration bank
//
// Contract
// RL1 - 16/17 mode: swallow low 4 bits, main above
// RL2 - Aux powerdown bit: 0 runs, 1 stops, tristates
// RL3 - Auto powerup: frequency word write clears aux powerdown
// RL4 - Chip enable low forces aux loop down
// RL5 - Aux reference divide 12-bit, 3 to 4095
// RL6 - Main pump gain is code plus one units
// RL7 - Host always writes words zero through four
// RL8 - Access bit 0 is one; 1-3 select optionals
// RL9 - Default-mode register forced wholly to defaults
// RL10 - Each optional register selected independently
// RL11 - Defaults: R5, R6 zero; R7 bits 11, 8
// RL12 - Default mode: all listed features read disabled
// RL13 - Aux prescaler select: 0 is 8/9, 1 is 16/17
// RL14 - Auto powerup powers both loops; chip enable gates
// RL15 - Low four bits address; 0111 is word three
`ifndef SDAC_CONSTS_VH
`define SDAC_CONSTS_VH
`define SDAC_WORD_W 24
`define SDAC_ADDR_W0 4'h0
`define SDAC_ADDR_W1 4'h3
`define SDAC_ADDR_W2 4'h5
`define SDAC_ADDR_W3 4'h7
`define SDAC_ADDR_W4 4'h9
`define SDAC_ADDR_W5 4'hb
`define SDAC_ADDR_W6 4'hd
`define SDAC_ADDR_W7 4'hf
`define SDAC_MAIN_PD_BIT 23
`define SDAC_AUX_PD_BIT 23
`define SDAC_AUX_N_MSB 22
`define SDAC_AUX_N_LSB 4
`define SDAC_SWALLOW_W 4
`define SDAC_AUX_R_MSB 15
`define SDAC_AUX_R_LSB 4
`define SDAC_GAIN_MSB 19
`define SDAC_GAIN_LSB 16
`define SDAC_ACC_LSB 20
`define SDAC_AUTO_POWERUP_BIT 23
`define SDAC_AUX_PSEL_BIT 8
`define SDAC_AUX_R_MIN 12'h003
`define SDAC_W5_DEFAULT 24'h00000b
`define SDAC_W6_DEFAULT 24'h00000d
`define SDAC_W7_DEFAULT 24'h00090f
`define SDAC_W7_LOCKDETECT_QUARTER_ADJUST_BIT 13
`define SDAC_W7_AUX_RST_BIT 7
`define SDAC_W7_MAIN_RST_BIT 6
`define SDAC_W7_AUX_TRI_BIT 5
`define SDAC_W7_MAIN_TRI_BIT 4
`endif

// ---- rtl/sdac_bank.v ----
// Serial configuration bank: shift port, register words and derived controls
`timescale 1ns/1ps
`default_nettype none
`include "sdac_consts.vh"
module sdac_bank (
    input wire clk_sys_i,
    input wire reset_i,
    input wire ser_clk_i,
    input wire ser_data_i,
    input wire ser_le_i,
    input wire chip_en_i,
    output reg main_loop_powerdown_o,
    output reg aux_loop_powerdown_o,
    output reg aux_pump_hiz_o,
    output reg main_pump_hiz_o,
    output reg aux_prescaler_16_o,
    output reg [14:0] aux_main_count_o,
    output reg [3:0] aux_swallow_count_o,
    output reg [11:0] aux_ref_div_o,
    output reg aux_ref_div_bad_o,
    output reg [4:0] main_pump_gain_mult_o,
    output reg access_bit0_bad_o,
    output reg [9:0] main_fraction_denominator_o,
    output reg [9:0] main_fraction_numerator_o,
    output reg [1:0] cycle_slip_reduction_o,
    output reg [3:0] fastlock_pump_current_o,
    output reg [13:0] fastlock_timeout_count_o,
    output reg lockdetect_quarter_adjust_o,
    output reg main_counter_reset_o,
    output reg aux_counter_reset_o,
    output reg main_pump_tristate_o,
    output reg aux_pump_tristate_o
);

// ----------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------
reg [1:0] sck_s_r;
reg [1:0] sdi_s_r;
reg [1:0] sle_s_r;
reg [1:0] ce_s_r;
reg sck_d_r;
reg sle_d_r;
always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
        sck_s_r <= 2'h0;
        sdi_s_r <= 2'h0;
        sle_s_r <= 2'h0;
        ce_s_r <= 2'h0;
        sck_d_r <= 1'b0;
        sle_d_r <= 1'b0;
    end else begin
        sck_s_r <= {sck_s_r[0], ser_clk_i};
        sdi_s_r <= {sdi_s_r[0], ser_data_i};
        sle_s_r <= {sle_s_r[0], ser_le_i};
        ce_s_r <= {ce_s_r[0], chip_en_i};
        sck_d_r <= sck_s_r[1];
        sle_d_r <= sle_s_r[1];
    end
end
wire sck_rise = sck_s_r[1] & ~sck_d_r;
wire le_rise = sle_s_r[1] & ~sle_d_r;
wire ce_on = ce_s_r[1];

// ----------------------------------------------------------------
// Shift register and word store
// ----------------------------------------------------------------
reg [23:0] shift_r;
reg [23:0] w0_r, w1_r, w2_r, w3_r, w4_r, w5_r, w6_r, w7_r;
wire [3:0] addr = shift_r[3:0];
wire wr0 = le_rise && addr == `SDAC_ADDR_W0; // see RL15
wire auto_powerup_fire = wr0 && w4_r[`SDAC_AUTO_POWERUP_BIT] && ce_on; // see RL3 see RL14

always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
        shift_r <= 24'h000000;
        w0_r <= 24'h000000;
        w1_r <= 24'h000000;
        w2_r <= 24'h000000;
        w3_r <= 24'h000000;
        w4_r <= 24'h000000;
        w5_r <= `SDAC_W5_DEFAULT;
        w6_r <= `SDAC_W6_DEFAULT;
        w7_r <= `SDAC_W7_DEFAULT;
    end else begin
        if (sck_rise)
            shift_r <= {shift_r[22:0], sdi_s_r[1]};
        if (le_rise) begin
            // Writes land whatever the access bits; defaults are muxed later
            case (addr)
                `SDAC_ADDR_W0: w0_r <= shift_r;
                `SDAC_ADDR_W1: w1_r <= shift_r;
                `SDAC_ADDR_W2: w2_r <= shift_r;
                `SDAC_ADDR_W3: w3_r <= shift_r; // see RL15
                `SDAC_ADDR_W4: w4_r <= shift_r;
                `SDAC_ADDR_W5: w5_r <= shift_r;
                `SDAC_ADDR_W6: w6_r <= shift_r;
                `SDAC_ADDR_W7: w7_r <= shift_r;
                default: w0_r <= w0_r;
            endcase
        end
        // Auto powerup clears stored powerdown bits; it fires only on a word
        // zero write, so no write to word one or two shares its edge
        if (auto_powerup_fire) begin
            w1_r[`SDAC_MAIN_PD_BIT] <= 1'b0; // see RL14
            w2_r[`SDAC_AUX_PD_BIT] <= 1'b0; // see RL3
        end
    end
end

// ----------------------------------------------------------------
// Access selection of optional words
// ----------------------------------------------------------------
wire [3:0] access = w3_r[`SDAC_ACC_LSB+3:`SDAC_ACC_LSB]; // see RL8
// Each optional word picks its own source, see RL10
wire [23:0] e5 = access[1] ? w5_r : `SDAC_W5_DEFAULT; // see RL9 see RL11
wire [23:0] e6 = access[2] ? w6_r : `SDAC_W6_DEFAULT; // see RL9 see RL11
wire [23:0] e7 = access[3] ? w7_r : `SDAC_W7_DEFAULT; // see RL9 see RL11
wire [18:0] aux_n = w2_r[`SDAC_AUX_N_MSB:`SDAC_AUX_N_LSB];
wire [11:0] aux_r = w3_r[`SDAC_AUX_R_MSB:`SDAC_AUX_R_LSB];
wire [3:0] gain = w3_r[`SDAC_GAIN_MSB:`SDAC_GAIN_LSB];

// ----------------------------------------------------------------
// Output registers
// ----------------------------------------------------------------
always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
        main_loop_powerdown_o <= 1'b1;
        aux_loop_powerdown_o <= 1'b1;
        aux_pump_hiz_o <= 1'b1;
        main_pump_hiz_o <= 1'b1;
        aux_prescaler_16_o <= 1'b0;
        aux_main_count_o <= 15'h0000;
        aux_swallow_count_o <= 4'h0;
        aux_ref_div_o <= 12'h000;
        aux_ref_div_bad_o <= 1'b0;
        main_pump_gain_mult_o <= 5'h01;
        access_bit0_bad_o <= 1'b0;
        main_fraction_denominator_o <= 10'h000;
        main_fraction_numerator_o <= 10'h000;
        cycle_slip_reduction_o <= 2'h0;
        fastlock_pump_current_o <= 4'h0;
        fastlock_timeout_count_o <= 14'h0000;
        lockdetect_quarter_adjust_o <= 1'b0;
        main_counter_reset_o <= 1'b0;
        aux_counter_reset_o <= 1'b0;
        main_pump_tristate_o <= 1'b0;
        aux_pump_tristate_o <= 1'b0;
    end else begin
        // Chip enable first, then the stored bit (already cleared by AUTO_POWERUP)
        aux_loop_powerdown_o <= ~ce_on | w2_r[`SDAC_AUX_PD_BIT]; // see RL2 see RL4
        aux_pump_hiz_o <= ~ce_on | w2_r[`SDAC_AUX_PD_BIT]; // see RL2
        main_loop_powerdown_o <= ~ce_on | w1_r[`SDAC_MAIN_PD_BIT]; // see RL14
        main_pump_hiz_o <= ~ce_on | w1_r[`SDAC_MAIN_PD_BIT];
        aux_prescaler_16_o <= w4_r[`SDAC_AUX_PSEL_BIT]; // see RL13
        if (w4_r[`SDAC_AUX_PSEL_BIT]) begin
            aux_main_count_o <= aux_n[18:4]; // see RL1
            aux_swallow_count_o <= aux_n[3:0];
        end else begin
            aux_main_count_o <= {1'b0, aux_n[16:3]};
            aux_swallow_count_o <= {1'b0, aux_n[2:0]};
        end
        aux_ref_div_o <= aux_r; // see RL5
        aux_ref_div_bad_o <= aux_r < `SDAC_AUX_R_MIN; // see RL5
        main_pump_gain_mult_o <= {1'b0, gain} + 5'h01; // see RL6
        access_bit0_bad_o <= ~access[0]; // see RL8
        main_fraction_denominator_o <= e5[23:14]; // see RL12
        main_fraction_numerator_o <= e5[13:4];
        cycle_slip_reduction_o <= e6[23:22];
        fastlock_pump_current_o <= e6[21:18];
        fastlock_timeout_count_o <= e6[17:4];
        lockdetect_quarter_adjust_o <= e7[`SDAC_W7_LOCKDETECT_QUARTER_ADJUST_BIT];
        aux_counter_reset_o <= e7[`SDAC_W7_AUX_RST_BIT];
        main_counter_reset_o <= e7[`SDAC_W7_MAIN_RST_BIT];
        aux_pump_tristate_o <= e7[`SDAC_W7_AUX_TRI_BIT];
        main_pump_tristate_o <= e7[`SDAC_W7_MAIN_TRI_BIT];
    end
end
endmodule
`default_nettype wire

// ---- test/sdac_checker.sv ----
// Assertions on the configuration bank ports
`timescale 1ns/1ps
`default_nettype none
module sdac_checker (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic ser_le_i,
    input wire logic chip_en_i,
    input wire logic main_loop_powerdown_o,
    input wire logic aux_loop_powerdown_o,
    input wire logic aux_pump_hiz_o,
    input wire logic main_pump_hiz_o,
    input wire logic [11:0] aux_ref_div_o,
    input wire logic aux_ref_div_bad_o,
    input wire logic [4:0] main_pump_gain_mult_o,
    input wire logic [13:0] fastlock_timeout_count_o
);
default clocking @(posedge clk_sys_i); endclocking
default disable iff (reset_i);
chk_ce_aux_down: assert property (!chip_en_i [*4] |-> aux_loop_powerdown_o)
    else $error("aux up, ce low");
chk_ce_main_down: assert property (!chip_en_i [*4] |-> main_loop_powerdown_o)
    else $error("main up, ce low");
chk_aux_hiz: assert property (aux_pump_hiz_o == aux_loop_powerdown_o)
    else $error("aux hiz mismatch");
chk_main_hiz: assert property (main_pump_hiz_o == main_loop_powerdown_o)
    else $error("main hiz mismatch");
chk_gain_range: assert property (main_pump_gain_mult_o inside {[1:16]})
    else $error("gain out of range");
chk_refdiv_flag: assert property (!$past(reset_i) |->
    aux_ref_div_bad_o == (aux_ref_div_o < 12'h003))
    else $error("ref flag wrong");
chk_ref_quiet: assert property (!ser_le_i [*8] |-> $stable(aux_ref_div_o))
    else $error("ref changed without latch");
chk_opt_quiet: assert property (!ser_le_i [*8] |->
    $stable(fastlock_timeout_count_o))
    else $error("option changed without latch");
cover property ($fell(aux_loop_powerdown_o));
cover property ($rose(aux_ref_div_bad_o));
cover property ($changed(fastlock_timeout_count_o));
endmodule
bind sdac_bank sdac_checker chk_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .ser_le_i(ser_le_i), .chip_en_i(chip_en_i),
    .main_loop_powerdown_o(main_loop_powerdown_o),
    .aux_loop_powerdown_o(aux_loop_powerdown_o),
    .aux_pump_hiz_o(aux_pump_hiz_o), .main_pump_hiz_o(main_pump_hiz_o),
    .aux_ref_div_o(aux_ref_div_o), .aux_ref_div_bad_o(aux_ref_div_bad_o),
    .main_pump_gain_mult_o(main_pump_gain_mult_o),
    .fastlock_timeout_count_o(fastlock_timeout_count_o));
`default_nettype wire

// ---- test/sdac_host.sv ----
// Host model shifting 24-bit words into the bank
`timescale 1ns/1ps
`default_nettype none
module sdac_host (
    input wire logic clk_i,
    output var logic sclk_o,
    output var logic sdat_o,
    output var logic le_o
);
initial begin
    sclk_o = 0;
    sdat_o = 0;
    le_o = 0;
end
// Link clock idles low between frames; data left inverted
task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
        @(negedge clk_i) sdat_o = w[i];
        sclk_o = 0;
        repeat (10) @(negedge clk_i);
        sclk_o = 1;
        repeat (10) @(negedge clk_i);
    end
    sclk_o = 0;
    sdat_o = ~w[0];
    le_o = 1;
    repeat (10) @(negedge clk_i);
    le_o = 0;
    repeat (12) @(negedge clk_i);
endtask
endmodule
`default_nettype wire

// ---- test/tb_synth_divider_access_config.sv ----
// Testbench for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb_synth_divider_access_config;
logic clk = 0, rst = 1, ce = 0, sc, sd, le, mpd, apd, ahz, p16, rb, ab, d4;
logic [14:0] mc;
logic [3:0] sw;
logic [11:0] rd;
logic [4:0] gm;
logic [9:0] den;
logic [13:0] tmo;
logic [9:0] num;
logic [1:0] cycle_slip_reduction;
logic [3:0] fpc;
logic arst, mrst, atri, mtri;
int error_cnt = 0, total_checks = 0;
always #2 clk = ~clk;
sdac_host host (.clk_i(clk), .sclk_o(sc), .sdat_o(sd), .le_o(le));
sdac_bank uut (.clk_sys_i(clk), .reset_i(rst), .ser_clk_i(sc),
    .ser_data_i(sd), .ser_le_i(le), .chip_en_i(ce),
    .main_loop_powerdown_o(mpd), .aux_loop_powerdown_o(apd),
    .aux_pump_hiz_o(ahz), .main_pump_hiz_o(), .aux_prescaler_16_o(p16),
    .aux_main_count_o(mc), .aux_swallow_count_o(sw), .aux_ref_div_o(rd),
    .aux_ref_div_bad_o(rb), .main_pump_gain_mult_o(gm),
    .access_bit0_bad_o(ab), .main_fraction_denominator_o(den),
    .main_fraction_numerator_o(num), .cycle_slip_reduction_o(cycle_slip_reduction),
    .fastlock_pump_current_o(fpc), .fastlock_timeout_count_o(tmo),
    .lockdetect_quarter_adjust_o(d4), .main_counter_reset_o(mrst),
    .aux_counter_reset_o(arst), .main_pump_tristate_o(mtri),
    .aux_pump_tristate_o(atri));
task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
        error_cnt++;
        $display("ERROR %s exp %h got %h", n, e, s);
    end
endtask
task automatic wr(input logic [23:0] w);
    host.send(w);
endtask
task automatic conclude;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
endtask
initial begin
    #200us;
    error_cnt++;
    conclude;
end
initial begin
    repeat (6) @(negedge clk);
    rst = 0;
    repeat (4) @(negedge clk);
    chk("apd", apd, 1);
    chk("gain", gm, 1);
    ce = 1;
    wr(24'h1f0027);
    chk("gain", gm, 16);
    chk("rbad", rb, 1);
    chk("acc0", ab, 0);
    wr(24'h00fff7);
    chk("gain", {rd, gm}, {12'hfff, 5'h01});
    chk("acc0", ab, 1);
    wr(24'h800109);
    wr(24'h800f05);
    chk("split", {p16, mc, sw}, {1'b1, 15'h000f, 4'h0});
    chk("apd", {apd, ahz}, 2'b11);
    wr(24'h000003);
    wr(24'h800003);
    wr(24'h000000);
    chk("auto_powerup", {apd, mpd}, 2'b00);
    ce = 0;
    wr(24'h000f05);
    chk("ce", apd, 1);
    wr(24'h800f05);
    wr(24'h000000);
    ce = 1;
    repeat (8) @(negedge clk);
    chk("ce", apd, 1);
    wr(24'hfffffb);
    wr(24'hfffffd);
    wr(24'hffffff);
    wr(24'h100037);
    chk("dflt", {den, tmo, d4}, 0);
    chk("dflt2", {num, cycle_slip_reduction, fpc}, 0);
    chk("dflt3", {arst, mrst, atri, mtri}, 0);
    wr(24'hb00037);
    chk("sel", {den, tmo, d4}, {10'h3ff, 14'h0, 1'b1});
    chk("sel2", {num, cycle_slip_reduction, fpc}, {10'h3ff, 2'h0, 4'h0});
    chk("sel3", {arst, mrst, atri, mtri}, 4'hf);
    wr(24'h000009);
    chk("split8", {p16, mc, sw}, {1'b0, 15'h001e, 4'h0});
    conclude;
end
endmodule
`default_nettype wire
